// file: hdl/fdm_pkg.sv
// Shared constants and types of the frame duty ratio modulator
package fdm_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NUM_MOD = 14;
	localparam int PERIOD_LOG2 = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int PIX_IN_W = 6;
	localparam int PIX_OUT_W = 3;
	localparam int AXI_AW = 8;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_DUTY_BASE = 8'h40;
	localparam int ADDR_WORD_LSB = 2;

	// Field positions and reset values
	localparam int CTRL_MODE_BIT = 0;
	localparam int STAT_MOD_LSB = 0;
	localparam int STAT_FRAME_LSB = 16;
	localparam logic CTRL_MODE_RESET = 1'b0;

	// Pixel code corners and RGB222 channel levels
	localparam logic [3:0] GRAY_OFF = 4'h0;
	localparam logic [3:0] GRAY_ON = 4'hf;
	localparam logic [1:0] CH_OFF = 2'h0;
	localparam logic [1:0] CH_LOW = 2'h1;
	localparam logic [1:0] CH_HIGH = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Mapping modes
	typedef enum logic {MAP_GRAY4 = 1'b0, MAP_RGB222 = 1'b1} fdm_mode_t;

	// Pixel carriers
	typedef struct packed {
		logic [PIX_IN_W-1:0] code;
	} fdm_pix_in_t;

	typedef struct packed {
		logic [PIX_OUT_W-1:0] bits;
	} fdm_pix_out_t;

endpackage

// file: hdl/fdm_fifo.sv
// Pixel FIFO with registered read data
`timescale 1ns/10ps
module fdm_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (DEPTH < 2 || (1 << PW) != DEPTH)
	begin : g_bad_depth
		$error("fdm_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic [PW:0] count;
	wire push;
	wire pop;

	// Memory refills the output register whenever it is empty or drained
	assign in_ready = (count != (PW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	// Storage array has no reset; pointers, fill level and the output valid flag are the control state
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wptr] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			wptr <= push ? wptr + 1'b1 : wptr;
			rptr <= pop ? rptr + 1'b1 : rptr;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Output register, one extra word of capacity beyond DEPTH
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data <= mem[rptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end

endmodule

// file: hdl/fdm_top.sv
// Frame duty ratio modulator: pixel mapping, modulators and AXI4-Lite registers
//
// Notes on behaviour
// - Modulators step once per frame on vsync
// - Same level gives same value whole frame
// - Active frames spread evenly across period
// - Period power of two, Bresenham accumulator
// - Output active when decision takes increment
// - Gray code 0 off, code 15 on
// - Gray codes 1..14 use modulator code-1
// - Binary output, duty set per modulator
// - RGB222 channels mapped independently to bits
// - Channel 0 off, 3 on, else modulators
// - Red bits 5:4, green 3:2, blue 1:0
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module fdm_top
#(
	parameter int DUTY_W = fdm_pkg::PERIOD_LOG2,
	parameter int DEPTH = fdm_pkg::FIFO_DEPTH
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic VSYNC,
	input wire logic PIX_IN_VALID,
	output logic PIX_IN_READY,
	input wire fdm_pkg::fdm_pix_in_t PIX_IN,
	output logic PIX_OUT_VALID,
	input wire logic PIX_OUT_READY,
	output fdm_pkg::fdm_pix_out_t PIX_OUT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [fdm_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [fdm_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP
);

	import fdm_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (DUTY_W < 1 || DUTY_W > 8)
	begin : g_bad_duty
		$error("fdm_top duty width must lie between 1 and 8");
	end

	localparam logic [DUTY_W-1:0] ACC_INIT = DUTY_W'(1 << (DUTY_W - 1));
	localparam logic [DUTY_W-1:0] FRAME_LAST = '1;

	fdm_mode_t mode;
	logic [DUTY_W-1:0] duty [NUM_MOD];
	logic [DUTY_W-1:0] acc [NUM_MOD];
	logic [NUM_MOD-1:0] mod_out;
	logic [DUTY_W-1:0] frame_idx;
	logic vsync_q;
	wire frame_step;
	wire period_end;

	logic aw_held;
	logic w_held;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire wr_fire;
	wire wr_is_ctrl;
	wire wr_is_duty;
	wire [AXI_AW-1:0] wr_rel;
	wire [AXI_AW-1:0] wr_idx;
	wire wr_ok;
	wire rd_fire;
	wire [AXI_AW-1:0] rd_rel;
	wire [AXI_AW-1:0] rd_idx;
	wire rd_is_duty;
	wire rd_ok;
	logic [31:0] next_rdata;

	fdm_pix_in_t fifo_pix;
	wire fifo_valid;
	wire fifo_ready;
	logic [PIX_OUT_W-1:0] next_bits;
	logic [3:0] gray_code;

	// ------------------------------------------------------------
	// Frame event and period counter
	// ------------------------------------------------------------
	// Rising edge of vsync is the only moment modulators may move
	assign frame_step = VSYNC && !vsync_q;
	assign period_end = (frame_idx == FRAME_LAST);

	// One shared frame index keeps every modulator on the same period
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			vsync_q <= 1'b0;
			frame_idx <= '0;
		end
		else
		begin
			vsync_q <= VSYNC;
			if (frame_step)
				frame_idx <= frame_idx + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Modulators
	// ------------------------------------------------------------
	// The carry of duty plus decision variable is the Bresenham step to the next
	// activity value; starting at half the period centres the on frames in their slots.
	for (genvar i = 0; i < NUM_MOD; i++)
	begin : g_mod
		wire [DUTY_W:0] sum;
		assign sum = {1'b0, acc[i]} + {1'b0, duty[i]};
		always_ff @(posedge CLK_SYS or posedge SYS_RST)
		begin
			if (SYS_RST)
			begin
				acc[i] <= ACC_INIT;
				mod_out[i] <= 1'b0;
			end
			else if (frame_step)
			begin
				mod_out[i] <= sum[DUTY_W];
				acc[i] <= period_end ? ACC_INIT : sum[DUTY_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Pixel path
	// ------------------------------------------------------------
	// Buffer absorbs panel stalls; the producer sees PIX_IN_READY drop
	fdm_fifo #(
		.WIDTH(PIX_IN_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.in_valid(PIX_IN_VALID),
		.in_ready(PIX_IN_READY),
		.in_data(PIX_IN.code),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_pix.code)
	);

	// Output stage takes a pixel when empty or when the panel drains it
	assign fifo_ready = !PIX_OUT_VALID || PIX_OUT_READY;
	assign gray_code = fifo_pix.code[3:0];

	// Mapping reads only the frame-stable modulator outputs, so every
	// pixel of one level gets the same bit throughout a frame.
	always_comb
	begin
		next_bits = '0;
		case (mode)
			MAP_GRAY4:
			begin
				if (gray_code == GRAY_OFF)
					next_bits[0] = 1'b0;
				else if (gray_code == GRAY_ON)
					next_bits[0] = 1'b1;
				else
					next_bits[0] = mod_out[gray_code - 4'h1];
			end
			MAP_RGB222:
			begin
				for (int c = 0; c < PIX_OUT_W; c++)
				begin
					case (fifo_pix.code[2*c +: 2])
						CH_OFF: next_bits[c] = 1'b0;
						CH_LOW: next_bits[c] = mod_out[2*c];
						CH_HIGH: next_bits[c] = mod_out[2*c + 1];
						default: next_bits[c] = 1'b1;
					endcase
				end
			end
			default: next_bits = '0;
		endcase
	end

	// Registered panel output
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			PIX_OUT_VALID <= 1'b0;
			PIX_OUT.bits <= '0;
		end
		else if (fifo_ready)
		begin
			PIX_OUT_VALID <= fifo_valid;
			if (fifo_valid)
				PIX_OUT.bits <= next_bits;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	// Address and data may come in either order; each is held until both
	assign S_AXI_AWREADY = !aw_held;
	assign S_AXI_WREADY = !w_held;
	assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
	assign wr_rel = aw_addr - ADDR_DUTY_BASE;
	assign wr_idx = wr_rel >> ADDR_WORD_LSB;
	assign wr_is_ctrl = (aw_addr == ADDR_CTRL);
	assign wr_is_duty = (aw_addr >= ADDR_DUTY_BASE) && (wr_idx < AXI_AW'(NUM_MOD));
	// Status is read-only, so a write there answers as an error
	assign wr_ok = wr_is_ctrl || wr_is_duty;

	// Capture of address and data beats
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= {S_AXI_AWADDR[AXI_AW-1:ADDR_WORD_LSB], 2'b00};
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			S_AXI_BVALID <= 1'b0;
	end

	// Control and duty registers; all fields live in byte lane 0
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			mode <= fdm_mode_t'(CTRL_MODE_RESET);
			for (int i = 0; i < NUM_MOD; i++)
				duty[i] <= '0;
		end
		else if (wr_fire && w_strb[0])
		begin
			if (wr_is_ctrl)
				mode <= fdm_mode_t'(w_data[CTRL_MODE_BIT]);
			if (wr_is_duty)
				duty[wr_idx[3:0]] <= w_data[DUTY_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
	assign rd_rel = S_AXI_ARADDR - ADDR_DUTY_BASE;
	assign rd_idx = rd_rel >> ADDR_WORD_LSB;
	assign rd_is_duty = (S_AXI_ARADDR >= ADDR_DUTY_BASE) && (rd_idx < AXI_AW'(NUM_MOD));
	assign rd_ok = rd_is_duty || ({S_AXI_ARADDR[AXI_AW-1:ADDR_WORD_LSB], 2'b00} == ADDR_CTRL)
		|| ({S_AXI_ARADDR[AXI_AW-1:ADDR_WORD_LSB], 2'b00} == ADDR_STATUS);

	// Read data select; unmapped words read as zero with an error
	always_comb
	begin
		next_rdata = '0;
		if (rd_is_duty)
			next_rdata[DUTY_W-1:0] = duty[rd_idx[3:0]];
		else if ({S_AXI_ARADDR[AXI_AW-1:ADDR_WORD_LSB], 2'b00} == ADDR_CTRL)
			next_rdata[CTRL_MODE_BIT] = mode;
		else if ({S_AXI_ARADDR[AXI_AW-1:ADDR_WORD_LSB], 2'b00} == ADDR_STATUS)
		begin
			next_rdata[STAT_MOD_LSB +: NUM_MOD] = mod_out;
			next_rdata[STAT_FRAME_LSB +: DUTY_W] = frame_idx;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			S_AXI_RVALID <= 1'b0;
	end

endmodule

// file: dv/fdm_panel.sv
// Panel model that takes physical pixels at a varying pace
`timescale 1ns/10ps
module fdm_panel (
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	output logic ready
);
	logic [1:0] phase;

	// Free phase counter; one cycle in four is refused to vary the pace
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	// Stall holds ready low so the pixel buffer backs up
	assign ready = !stall && (phase != 2'h3);
endmodule

// file: dv/fdm_top_properties.sv
// Port checker of the frame duty ratio modulator
`timescale 1ns/10ps
module fdm_top_properties
	import fdm_pkg::*;
#(
	parameter int DEPTH = fdm_pkg::FIFO_DEPTH
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic PIX_OUT_VALID,
	input wire logic PIX_OUT_READY,
	input wire fdm_pkg::fdm_pix_out_t PIX_OUT,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [fdm_pkg::AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [fdm_pkg::AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP
);
	import fdm_pkg::*;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);

	// Address and data taken together, and a read address taken
	sequence seq_wr;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence seq_rd;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence

	AST_OUT_HOLD: assert property (PIX_OUT_VALID && !PIX_OUT_READY |=>
		PIX_OUT_VALID && $stable(PIX_OUT)) else $error("pixel dropped while panel stalls");
	AST_WR_LATENCY: assert property (seq_wr |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID)
		else $error("write response not two cycles after address");
	AST_WR_BUSY: assert property (seq_wr |=> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("second write taken while one is held");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response not held");
	AST_STATUS_RO: assert property (seq_wr ##0 (S_AXI_AWADDR[7:2] == ADDR_STATUS[7:2])
		|-> ##2 S_AXI_BRESP == RESP_SLVERR) else $error("status write not refused");
	AST_RD_LATENCY: assert property (seq_rd |=> S_AXI_RVALID)
		else $error("read data late");
	AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken while data pending");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
		$stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("read data not held");
	AST_RD_UNMAPPED: assert property (seq_rd ##0 (S_AXI_ARADDR[7:2] > 6'h1d) |=>
		S_AXI_RDATA == 32'h0 && S_AXI_RRESP == RESP_SLVERR) else $error("bad unmapped read");
endmodule

bind fdm_top fdm_top_properties #(.DEPTH(DEPTH)) chk_u (
	.CLK_SYS, .SYS_RST, .PIX_OUT_VALID, .PIX_OUT_READY, .PIX_OUT,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP
);

// file: dv/tb.sv
// Self-checking bench of the frame duty ratio modulator
`timescale 1ns/10ps
`define CHK(nm, e, g) check(nm, e, g)
module tb;
	import fdm_pkg::*;
	logic clk, rst, vs, iv, ir, ov, o_r, stall, mode;
	logic aw_v, aw_r, w_v, w_r, bv, b_r, ar_v, ar_r, r_v, r_r;
	logic [7:0] aw_a, ar_a;
	logic [31:0] w_d, r_d, rd, seed;
	logic [1:0] b_s, r_s;
	fdm_pix_in_t pin;
	fdm_pix_out_t pout;
	logic [5:0] acc [NUM_MOD];
	logic [5:0] duty [NUM_MOD];
	logic [NUM_MOD-1:0] mo;
	logic [5:0] frame;
	fdm_pix_out_t expq[$];
	int fail_count, samples_checked;

	fdm_top dut_u (.CLK_SYS(clk), .SYS_RST(rst), .VSYNC(vs), .PIX_IN_VALID(iv),
		.PIX_IN_READY(ir), .PIX_IN(pin), .PIX_OUT_VALID(ov), .PIX_OUT_READY(o_r),
		.PIX_OUT(pout), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r), .S_AXI_AWADDR(aw_a),
		.S_AXI_AWPROT(3'h0), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r), .S_AXI_WDATA(w_d),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(b_r), .S_AXI_BRESP(b_s),
		.S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARPROT(3'h0),
		.S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_s));
	fdm_panel panel_u (.clk(clk), .rst(rst), .stall(stall), .ready(o_r));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Expectation and reporting helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Physical bits from the modulator model; corners never touch a modulator
	function automatic fdm_pix_out_t map_pix(input logic [5:0] c);
		fdm_pix_out_t p;
		logic [1:0] v;
		p.bits = 3'h0;
		if (mode == MAP_GRAY4)
			p.bits[0] = (c[3:0] == GRAY_ON) || (c[3:0] != GRAY_OFF && mo[c[3:0] - 4'h1]);
		else
			for (int ch = 0; ch < 3; ch++)
			begin
				v = c[2*ch +: 2];
				p.bits[ch] = (v == 2'h3) || (v != CH_OFF && mo[2*ch + v - 1]);
			end
		return p;
	endfunction

	// One frame step of every decision variable
	function automatic void step_model();
		logic [6:0] s;
		for (int i = 0; i < NUM_MOD; i++)
		begin
			s = {1'b0, acc[i]} + {1'b0, duty[i]};
			mo[i] = s[6];
			acc[i] = (frame == 6'h3f) ? 6'h20 : s[5:0];
		end
		frame = frame + 6'h1;
	endfunction

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic give_up();
		fail_count++;
		stop_test();
	endtask

	// ------------------------------------------------------------
	// Bus and stream drivers
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!done && n < 200)
		begin
			@(posedge clk);
			n++;
			if (aw_v && aw_r)
				aw_v <= 1'b0;
			if (w_v && w_r)
				w_v <= 1'b0;
			if (bv)
			begin
				done = 1'b1;
				b_r <= 1'b0;
				`CHK("bresp", er, b_s);
			end
		end
		if (!done)
			give_up();
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		while (!done && n < 200)
		begin
			@(posedge clk);
			n++;
			if (ar_v && ar_r)
				ar_v <= 1'b0;
			if (r_v)
			begin
				done = 1'b1;
				rd = r_d;
				r_r <= 1'b0;
				`CHK("rresp", er, r_s);
			end
		end
		if (!done)
			give_up();
	endtask

	// Valid stays up across calls so bursts run back to back
	task automatic push(input logic [5:0] c);
		int n;
		n = 0;
		pin <= c;
		iv <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!ir && n < 200);
		if (!ir)
			give_up();
		expq.push_back(map_pix(c));
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (expq.size() != 0 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		if (expq.size() != 0)
			give_up();
	endtask

	// Panel side monitor; sampled before the edge's own updates land
	always @(posedge clk)
		if (!rst && ov && o_r)
		begin
			if (expq.size() == 0)
				`CHK("spare pixel", 1'b0, 1'b1);
			else
				`CHK("pix_out", expq.pop_front(), pout);
		end

	initial
	begin
		int n;
		{rst, vs, iv, stall, aw_v, w_v, b_r, ar_v, r_r, mode} = 10'h200;
		{pin, aw_a, ar_a, w_d, mo, frame, fail_count, samples_checked} = '0;
		seed = 32'h000156cc;
		for (int i = 0; i < NUM_MOD; i++)
		begin
			acc[i] = 6'h20;
			duty[i] = 6'h00;
		end
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		axi_rd(ADDR_STATUS, RESP_OKAY);
		`CHK("status reset", 32'h0, rd);
		axi_rd(8'hfc, RESP_SLVERR);
		`CHK("unmapped read", 32'h0, rd);
		axi_wr(ADDR_STATUS, 32'hffffffff, RESP_SLVERR);
		// Duty corners 0 and 63 at the two ends of the bank
		for (int i = 0; i < NUM_MOD; i++)
		begin
			seed = lfsr(seed);
			duty[i] = (i == 0) ? 6'h00 : (i == NUM_MOD - 1) ? 6'h3f : seed[5:0];
			axi_wr(ADDR_DUTY_BASE + 8'(4 * i), {26'h0, duty[i]}, RESP_OKAY);
		end
		axi_rd(ADDR_DUTY_BASE + 8'h14, RESP_OKAY);
		`CHK("duty readback", {26'h0, duty[5]}, rd);
		// More than one period so the reload is crossed
		for (int f = 0; f < 70; f++)
		begin
			mode = f[0];
			axi_wr(ADDR_CTRL, {31'h0, mode}, RESP_OKAY);
			vs <= 1'b1;
			repeat (3) @(posedge clk);
			vs <= 1'b0;
			repeat (3) @(posedge clk);
			step_model();
			axi_rd(ADDR_STATUS, RESP_OKAY);
			`CHK("status", {10'h0, frame, 2'h0, mo}, rd);
			for (int k = 0; k < 20; k++)
			begin
				seed = lfsr(seed);
				push((k < 16) ? {f[2:1], k[3:0]} : seed[5:0]);
			end
			iv <= 1'b0;
			drain();
		end
		// Fill the buffer against a stalled panel, then let it drain; capacity is
		// the buffer depth plus the buffer's output word plus the panel register
		stall <= 1'b1;
		iv <= 1'b1;
		n = 0;
		while (n < 40)
		begin
			seed = lfsr(seed);
			pin <= seed[5:0];
			@(posedge clk);
			if (!ir)
				break;
			expq.push_back(map_pix(pin));
			n++;
		end
		`CHK("buffer depth", FIFO_DEPTH + 2, n);
		iv <= 1'b0;
		stall <= 1'b0;
		drain();
		stop_test();
	end
endmodule
